// ### logic/lpoc_pkg.sv
// constants, register map and types for the led_drive_polarity output control block
package lpoc_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 12;
  localparam int DUTY_W = 7;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_PIN_STATE = 10'h010;
  localparam logic [9:0] IDX_CONFIG = 10'h020;
  localparam logic [9:0] IDX_OUT_TYPE = 10'h071;
  localparam logic [9:0] IDX_LINK = 10'h072;
  localparam logic [9:0] IDX_POLARITY = 10'h073;
  localparam logic [9:0] IDX_HOST_ACT = 10'h074;
  localparam logic [9:0] IDX_MIRROR = 10'h079;
  localparam logic [9:0] IDX_BEHAV_LO = 10'h081;
  localparam logic [9:0] IDX_BEHAV_HI = 10'h082;
  localparam logic [9:0] IDX_MIN_DUTY = 10'h090;
  localparam logic [9:0] IDX_MAX_DUTY = 10'h091;
  // reset values
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_HOST_ACT = 8'h00;
  localparam logic [7:0] RST_LINK = 8'h00;
  localparam logic [7:0] RST_MIRROR = 8'h00;
  localparam logic [7:0] RST_OUT_TYPE = 8'h00;
  localparam logic [7:0] RST_BEHAV = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [6:0] RST_MIN_DUTY = 7'h00;
  localparam logic [6:0] RST_MAX_DUTY = 7'h64;
  // field positions
  localparam int CFG_BLOCK_MIRROR_BIT = 0;
  // duty scale: one pwm period is this many clocks, one per percent
  localparam logic [6:0] DUTY_FULL = 7'h64;
  localparam logic [6:0] PWM_LAST = 7'h63;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // behavior select encodings
  typedef enum logic [1:0] {
    LPOC_BEH_DIRECT = 2'h0,
    LPOC_BEH_BREATHE = 2'h1,
    LPOC_BEH_PULSE1 = 2'h2,
    LPOC_BEH_PULSE2 = 2'h3
  } lpoc_beh_t;
  typedef enum {LPOC_RAMP_UP, LPOC_RAMP_DOWN} lpoc_ramp_t;
endpackage : lpoc_pkg

// ### logic/lpoc_top.sv
// eight channel led_drive_polarity, linking and host actuation block with axi4-lite registers
//
// Summary of operation
// - linked led with detected touch is actuated and runs direct drive, or the breathe ramp for any other behavior select
// - eight bit read/write polarity register, bit n is led n+1, resets to zero
// - polarity write copies into mirror bits unless mirror coupling is blocked
// - linked led touch counts exactly like host actuation bit one
// - inverted: duty is low time; idle runs at minimum duty
// - inverted breathe ramps low time from minimum up to maximum duty
// - non-inverted: duty is high time; idle gives 100 minus minimum brightness
// - non-inverted breathe ramps brightness from 100-min to 100-max
// - mirror bits change only which end the breathe ramp starts from, never pin drive directly
// - inverted polarity with actuation one drives the pin low
// - non-inverted actuation drives high in push-pull, releases in open-drain
// - eight bit read/write host actuation register for unlinked leds, resets zero
// - host actuation bit is ignored while the led is linked
// - polarity sets idle pin state, behavior select sets actuated state
// - actuation zero gives minimum duty, one gives maximum duty or behavior
// - non-inverted direct peak is 100-max, breathing peak is 100-min
// - inverted idle ignores maximum duty and runs at minimum duty only
// - behavior starts on touch and stops on release; host bit stands in
// - mirror one starts breathe at maximum duty ramping down, zero at minimum ramping up
// - open-drain pulls low or releases; push-pull drives both levels
`timescale 1ns/1ps
module lpoc_top (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst, // synchronous, active high
  input wire logic [7:0] sensor_touch, // touch detect per sensor input, asynchronous
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [7:0] led_pin_o, // led pin output level
  output logic [7:0] led_pin_oe // led pin output enable, high while driving
);

  function automatic logic idx_mapped(input logic [9:0] idx);
    case (idx)
      lpoc_pkg::IDX_PIN_STATE, lpoc_pkg::IDX_CONFIG, lpoc_pkg::IDX_OUT_TYPE, lpoc_pkg::IDX_LINK,
      lpoc_pkg::IDX_POLARITY, lpoc_pkg::IDX_HOST_ACT, lpoc_pkg::IDX_MIRROR, lpoc_pkg::IDX_BEHAV_LO,
      lpoc_pkg::IDX_BEHAV_HI, lpoc_pkg::IDX_MIN_DUTY, lpoc_pkg::IDX_MAX_DUTY: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // register file and bus state
  logic [7:0] polarity_reg, polarity_next;
  logic [7:0] host_act_reg, host_act_next;
  logic [7:0] link_reg, link_next;
  logic [7:0] mirror_reg, mirror_next;
  logic [7:0] out_type_reg, out_type_next;
  logic [15:0] behav_reg, behav_next;
  logic [7:0] config_reg, config_next;
  logic [6:0] min_duty_reg, min_duty_next;
  logic [6:0] max_duty_reg, max_duty_next;
  logic aw_hold_reg, aw_hold_next;
  logic [9:0] aw_idx_reg, aw_idx_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_wr;
  logic [9:0] ar_idx;
  logic [7:0] rd_byte;

  // touch synchroniser
  logic [7:0] touch_meta_reg;
  logic [7:0] touch_s_reg;

  // pwm and breathe state
  logic [6:0] pwm_cnt_reg, pwm_cnt_next;
  logic [6:0] lvl_reg [lpoc_pkg::NUM_CH], lvl_next [lpoc_pkg::NUM_CH];
  lpoc_pkg::lpoc_ramp_t dir_reg [lpoc_pkg::NUM_CH], dir_next [lpoc_pkg::NUM_CH];
  logic [7:0] pin_o_reg, pin_o_next;
  logic [7:0] pin_oe_reg, pin_oe_next;

  // per channel combinational view
  logic [7:0] actuated;
  logic [7:0] breathing;
  logic [6:0] duty [lpoc_pkg::NUM_CH];

  assign do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign ar_idx = s_axi_araddr[11:2];

  always_comb begin
    polarity_next = polarity_reg;
    host_act_next = host_act_reg;
    link_next = link_reg;
    mirror_next = mirror_reg;
    out_type_next = out_type_reg;
    behav_next = behav_reg;
    config_next = config_reg;
    min_duty_next = min_duty_reg;
    max_duty_next = max_duty_reg;
    aw_hold_next = aw_hold_reg;
    aw_idx_next = aw_idx_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    rd_byte = 8'h00;
    // address and data are taken independently, in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_hold_next = 1'b1;
      aw_idx_next = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_lane0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = idx_mapped(aw_idx_reg) ? lpoc_pkg::RESP_OKAY : lpoc_pkg::RESP_SLVERR;
      if (w_lane0_reg) begin
        case (aw_idx_reg)
          lpoc_pkg::IDX_POLARITY: begin
            polarity_next = w_data_reg;
            if (!config_reg[lpoc_pkg::CFG_BLOCK_MIRROR_BIT]) begin
              mirror_next = w_data_reg;
            end
          end
          lpoc_pkg::IDX_HOST_ACT: host_act_next = w_data_reg;
          lpoc_pkg::IDX_LINK: link_next = w_data_reg;
          lpoc_pkg::IDX_MIRROR: mirror_next = w_data_reg;
          lpoc_pkg::IDX_OUT_TYPE: out_type_next = w_data_reg;
          lpoc_pkg::IDX_BEHAV_LO: behav_next[7:0] = w_data_reg;
          lpoc_pkg::IDX_BEHAV_HI: behav_next[15:8] = w_data_reg;
          lpoc_pkg::IDX_CONFIG: config_next = w_data_reg;
          lpoc_pkg::IDX_MIN_DUTY: min_duty_next = w_data_reg[6:0];
          lpoc_pkg::IDX_MAX_DUTY: max_duty_next = w_data_reg[6:0];
          default: ;
        endcase
      end
    end
    awready_next = ~aw_hold_next & ~do_wr & ~bvalid_next;
    wready_next = ~w_hold_next & ~do_wr & ~bvalid_next;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      case (ar_idx)
        lpoc_pkg::IDX_POLARITY: rd_byte = polarity_reg;
        lpoc_pkg::IDX_HOST_ACT: rd_byte = host_act_reg;
        lpoc_pkg::IDX_LINK: rd_byte = link_reg;
        lpoc_pkg::IDX_MIRROR: rd_byte = mirror_reg;
        lpoc_pkg::IDX_OUT_TYPE: rd_byte = out_type_reg;
        lpoc_pkg::IDX_BEHAV_LO: rd_byte = behav_reg[7:0];
        lpoc_pkg::IDX_BEHAV_HI: rd_byte = behav_reg[15:8];
        lpoc_pkg::IDX_CONFIG: rd_byte = config_reg;
        lpoc_pkg::IDX_MIN_DUTY: rd_byte = {1'b0, min_duty_reg};
        lpoc_pkg::IDX_MAX_DUTY: rd_byte = {1'b0, max_duty_reg};
        lpoc_pkg::IDX_PIN_STATE: rd_byte = pin_o_reg | ~pin_oe_reg; // released pins read high
        default: rd_byte = 8'h00;
      endcase
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_byte};
      rresp_next = idx_mapped(ar_idx) ? lpoc_pkg::RESP_OKAY : lpoc_pkg::RESP_SLVERR;
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      polarity_reg <= lpoc_pkg::RST_POLARITY;
      host_act_reg <= lpoc_pkg::RST_HOST_ACT;
      link_reg <= lpoc_pkg::RST_LINK;
      mirror_reg <= lpoc_pkg::RST_MIRROR;
      out_type_reg <= lpoc_pkg::RST_OUT_TYPE;
      behav_reg <= {lpoc_pkg::RST_BEHAV, lpoc_pkg::RST_BEHAV};
      config_reg <= lpoc_pkg::RST_CONFIG;
      min_duty_reg <= lpoc_pkg::RST_MIN_DUTY;
      max_duty_reg <= lpoc_pkg::RST_MAX_DUTY;
      aw_hold_reg <= 1'b0;
      aw_idx_reg <= 10'h000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= lpoc_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= lpoc_pkg::RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      polarity_reg <= polarity_next;
      host_act_reg <= host_act_next;
      link_reg <= link_next;
      mirror_reg <= mirror_next;
      out_type_reg <= out_type_next;
      behav_reg <= behav_next;
      config_reg <= config_next;
      min_duty_reg <= min_duty_next;
      max_duty_reg <= max_duty_next;
      aw_hold_reg <= aw_hold_next;
      aw_idx_reg <= aw_idx_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // touch inputs come from the sensing front end in another timing domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      touch_meta_reg <= 8'h00;
      touch_s_reg <= 8'h00;
    end else begin
      touch_meta_reg <= sensor_touch;
      touch_s_reg <= touch_meta_reg;
    end
  end

  // duty is the share of the period spent at the actuated level: low when inverted, high when not
  genvar g;
  generate
    for (g = 0; g < lpoc_pkg::NUM_CH; g++) begin : g_ch
      assign actuated[g] = link_reg[g] ? touch_s_reg[g] : host_act_reg[g];
      assign breathing[g] = behav_reg[2*g+1 -: 2] != lpoc_pkg::LPOC_BEH_DIRECT;
      // idle ignores max duty; direct uses max; breathe walks the ramp
      assign duty[g] = !actuated[g] ? min_duty_reg :
                       (breathing[g] ? lvl_reg[g] : max_duty_reg);
    end
  endgenerate

  always_comb begin
    logic a;
    logic v;
    a = 1'b0;
    v = 1'b0;
    pwm_cnt_next = (pwm_cnt_reg == lpoc_pkg::PWM_LAST) ? 7'h00 : pwm_cnt_reg + 7'h01;
    for (int i = 0; i < lpoc_pkg::NUM_CH; i++) begin
      lvl_next[i] = lvl_reg[i];
      dir_next[i] = dir_reg[i];
      // ramp restarts on each release, so a new touch always begins at the start point
      if (!actuated[i] || !breathing[i]) begin
        // mirror picks which end the ramp starts from; it never reaches the pin itself
        lvl_next[i] = mirror_reg[i] ? max_duty_reg : min_duty_reg;
        dir_next[i] = mirror_reg[i] ? lpoc_pkg::LPOC_RAMP_DOWN : lpoc_pkg::LPOC_RAMP_UP;
      end else if (pwm_cnt_reg == lpoc_pkg::PWM_LAST) begin
        case (dir_reg[i])
          lpoc_pkg::LPOC_RAMP_UP: begin
            if (lvl_reg[i] < max_duty_reg) lvl_next[i] = lvl_reg[i] + 7'h01;
            else dir_next[i] = lpoc_pkg::LPOC_RAMP_DOWN;
          end
          lpoc_pkg::LPOC_RAMP_DOWN: begin
            if (lvl_reg[i] > min_duty_reg) lvl_next[i] = lvl_reg[i] - 7'h01;
            else dir_next[i] = lpoc_pkg::LPOC_RAMP_UP;
          end
          default: dir_next[i] = lpoc_pkg::LPOC_RAMP_UP;
        endcase
      end
      a = pwm_cnt_reg < duty[i];
      v = polarity_reg[i] ? a : ~a;
      if (out_type_reg[i]) begin
        pin_o_next[i] = v;
        pin_oe_next[i] = 1'b1;
      end else begin
        pin_o_next[i] = 1'b0;
        pin_oe_next[i] = ~v;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_cnt_reg <= 7'h00;
      for (int i = 0; i < lpoc_pkg::NUM_CH; i++) begin
        lvl_reg[i] <= lpoc_pkg::RST_MIN_DUTY;
        dir_reg[i] <= lpoc_pkg::LPOC_RAMP_UP;
      end
      pin_o_reg <= 8'h00;
      pin_oe_reg <= 8'h00;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      lvl_reg <= lvl_next;
      dir_reg <= dir_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign led_pin_o = pin_o_reg;
  assign led_pin_oe = pin_oe_reg;

  // single channels stand for all; the channels are built from one generate body and one loop
  property p_pol_mirror_couple;
    @(posedge mclk) disable iff (rst)
      do_wr && w_lane0_reg && aw_idx_reg == lpoc_pkg::IDX_POLARITY && !config_reg[0]
      |=> mirror_reg == polarity_reg;
  endproperty
  a_pol_mirror_couple: assert property (p_pol_mirror_couple) else $error("mirror not coupled to polarity");

  property p_pol_mirror_block;
    @(posedge mclk) disable iff (rst)
      do_wr && aw_idx_reg == lpoc_pkg::IDX_POLARITY && config_reg[0] |=> $stable(mirror_reg);
  endproperty
  a_pol_mirror_block: assert property (p_pol_mirror_block) else $error("mirror changed while blocked");

  property p_reset_values;
    @(posedge mclk) $fell(rst) |-> polarity_reg == 8'h00 && host_act_reg == 8'h00 && !s_axi_bvalid;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values");

  property p_inv_act_low;
    @(posedge mclk) disable iff (rst)
      actuated[4] && !polarity_reg[4] && pwm_cnt_reg < duty[4] |=> !led_pin_o[4] && led_pin_oe[4];
  endproperty
  a_inv_act_low: assert property (p_inv_act_low) else $error("inverted actuated pin not low");

  property p_noninv_od_release;
    @(posedge mclk) disable iff (rst)
      actuated[0] && polarity_reg[0] && !out_type_reg[0] && pwm_cnt_reg < duty[0] |=> !led_pin_oe[0];
  endproperty
  a_noninv_od_release: assert property (p_noninv_od_release) else $error("open-drain pin not released");

  property p_inv_idle_min;
    @(posedge mclk) disable iff (rst)
      !actuated[7] && !polarity_reg[7] && out_type_reg[7] && pwm_cnt_reg >= min_duty_reg |=> led_pin_o[7];
  endproperty
  a_inv_idle_min: assert property (p_inv_idle_min) else $error("inverted idle pin not at min duty");

  property p_noninv_idle_min;
    @(posedge mclk) disable iff (rst)
      !actuated[2] && polarity_reg[2] && out_type_reg[2] && pwm_cnt_reg >= min_duty_reg |=> !led_pin_o[2];
  endproperty
  a_noninv_idle_min: assert property (p_noninv_idle_min) else $error("non-inverted idle pin wrong");

  property p_link_ignores_host;
    @(posedge mclk) disable iff (rst)
      link_reg[4] && host_act_reg[4] && !touch_s_reg[4] && !polarity_reg[4] && out_type_reg[4]
      && pwm_cnt_reg >= min_duty_reg |=> led_pin_o[4];
  endproperty
  a_link_ignores_host: assert property (p_link_ignores_host) else $error("linked led followed host bit");

  property p_touch_actuates;
    @(posedge mclk) disable iff (rst)
      link_reg[5] && touch_meta_reg[5] |=> actuated[5] || !link_reg[5];
  endproperty
  a_touch_actuates: assert property (p_touch_actuates) else $error("touch did not actuate linked led");

  c_write_done: cover property (@(posedge mclk) disable iff (rst) s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (@(posedge mclk) disable iff (rst) s_axi_rvalid && s_axi_rready);
  c_touch_drive: cover property (@(posedge mclk) disable iff (rst) link_reg[0] && actuated[0]);
  c_breathe_turn: cover property (@(posedge mclk) disable iff (rst) dir_reg[0] == lpoc_pkg::LPOC_RAMP_DOWN);

endmodule : lpoc_top

// ### testbench/lpoc_led_model.sv
// behavioural external leds with a pull-up on every pin
`timescale 1ns/1ps
module lpoc_led_model (
  input wire logic [7:0] led_pin_o, // pin level from the block
  input wire logic [7:0] led_pin_oe, // pin drive enable
  output logic [7:0] pin_level, // resolved wire level
  output logic [7:0] led_lit // led conducts while its pin sits low
);
  // a released pin floats up through the external resistor, never holds its last value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = led_pin_oe[i] ? led_pin_o[i] : 1'b1;
      led_lit[i] = !pin_level[i];
    end
  end
endmodule : lpoc_led_model

// ### testbench/lpoc_top_tb.sv
// self-checking bench: register access over axi4-lite and pwm duty on the led pins
`timescale 1ns/1ps
module lpoc_top_tb;
  localparam logic [11:0] A_POL = {lpoc_pkg::IDX_POLARITY, 2'b00};
  localparam logic [11:0] A_ACT = {lpoc_pkg::IDX_HOST_ACT, 2'b00};
  localparam logic [11:0] A_LINK = {lpoc_pkg::IDX_LINK, 2'b00};
  localparam logic [11:0] A_MIR = {lpoc_pkg::IDX_MIRROR, 2'b00};
  localparam logic [11:0] A_CFG = {lpoc_pkg::IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_OT = {lpoc_pkg::IDX_OUT_TYPE, 2'b00};
  localparam logic [11:0] A_MIN = {lpoc_pkg::IDX_MIN_DUTY, 2'b00};
  localparam logic [11:0] A_MAX = {lpoc_pkg::IDX_MAX_DUTY, 2'b00};
  localparam logic [11:0] A_PIN = {lpoc_pkg::IDX_PIN_STATE, 2'b00};
  localparam logic [11:0] A_BEH = {lpoc_pkg::IDX_BEHAV_LO, 2'b00};
  logic mclk;
  logic rst;
  logic [7:0] sensor_touch;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  int hi0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [7:0] led_pin_o;
  logic [7:0] led_pin_oe;
  logic [7:0] pin_level;
  logic [7:0] led_lit;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;

  lpoc_top lpoc_top_inst (.mclk(mclk), .rst(rst), .sensor_touch(sensor_touch),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe));

  lpoc_led_model lpoc_led_model_inst (.led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe),
    .pin_level(pin_level), .led_lit(led_lit));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task summarize;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, lpoc_pkg::RESP_OKAY);
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, {24'h000000, d});
    chk(rresp, r);
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  // one full pwm period of 100 clocks; duty 20 idle, 70 actuated
  task automatic meas(input logic [7:0] pol, input logic [7:0] act, input logic od);
    int hi[8];
    int bad;
    int d;
    bad = 0;
    foreach (hi[i]) hi[i] = 0;
    repeat (8) @(posedge mclk);
    repeat (100) begin
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        if (pin_level[i] === 1'b1) hi[i]++;
        if (od && led_pin_oe[i] === 1'b1 && led_pin_o[i] !== 1'b0) bad++;
        if (led_lit[i] === pin_level[i]) bad++;
      end
    end
    for (int i = 0; i < 8; i++) begin
      d = act[i] ? 70 : 20;
      chk(hi[i], pol[i] ? d : 100 - d);
    end
    chk(bad, 0);
  endtask : meas

  // a hung handshake ends the run here
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      summarize;
    end
  end

  initial begin
    rst = 1'b1;
    sensor_touch = 8'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(led_pin_oe, 8'h00);
    rd(A_POL, 8'h00, lpoc_pkg::RESP_OKAY);
    rd(A_ACT, 8'h00, lpoc_pkg::RESP_OKAY);
    rd(A_MIR, 8'h00, lpoc_pkg::RESP_OKAY);
    rd(A_LINK, 8'h00, lpoc_pkg::RESP_OKAY);
    wr(A_POL, 8'ha5);
    rd(A_POL, 8'ha5, lpoc_pkg::RESP_OKAY);
    rd(A_MIR, 8'ha5, lpoc_pkg::RESP_OKAY);
    wr(A_CFG, 8'h01);
    wr(A_POL, 8'h5a);
    rd(A_MIR, 8'ha5, lpoc_pkg::RESP_OKAY);
    wr(A_ACT, 8'h33);
    rd(A_ACT, 8'h33, lpoc_pkg::RESP_OKAY);
    // a write with lane 0 disabled must leave the register alone
    wstrb <= 4'h0;
    wr(A_ACT, 8'hcc);
    wstrb <= 4'hf;
    rd(A_ACT, 8'h33, lpoc_pkg::RESP_OKAY);
    rd(12'hffc, 8'h00, lpoc_pkg::RESP_SLVERR);
    wr(A_MIN, 8'h14);
    wr(A_MAX, 8'h46);
    wr(A_OT, 8'hff);
    wr(A_POL, 8'h0f);
    meas(8'h0f, 8'h33, 1'b0);
    // linked channels follow the sensor, their host bits are ignored
    wr(A_LINK, 8'hf0);
    sensor_touch <= 8'h60;
    meas(8'h0f, 8'h63, 1'b0);
    wr(A_OT, 8'h00);
    meas(8'h0f, 8'h63, 1'b1);
    wr(A_MIR, 8'hff);
    meas(8'h0f, 8'h63, 1'b1);
    sensor_touch <= 8'h90;
    meas(8'h0f, 8'h93, 1'b1);
    // empty and full duty hold the pins still, so the level register can be read
    wr(A_MIN, 8'h00);
    wr(A_MAX, 8'h64);
    rd(A_PIN, 8'h63, lpoc_pkg::RESP_OKAY);
    // mirrored breathe on led 1 starts at full duty and steps down once a period
    wr(A_BEH, 8'h01);
    hi0 = 0;
    repeat (1000) @(posedge mclk);
    repeat (100) begin
      @(posedge mclk);
      if (pin_level[0] === 1'b1) hi0++;
    end
    chk(hi0 >= 85 && hi0 <= 95, 1);
    summarize;
  end
endmodule : lpoc_top_tb
